//--- lp_ctrl.sv
// The placing of the registers and the Wishbone slave port were decided locally.
`timescale 1ns/1ps
`include "lp_params.svh"

module low_power_wake_and_vector_control
   import lp_pkg::*;
#(
   parameter int REC_LONG_CYC  = `REC_LONG,
   parameter int REC_SHORT_CYC = `REC_SHORT
)(
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // Wishbone slave
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [3:0]  adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic      [31:0] dat_o,
   output logic             ack_o,
   // CPU core
   input  wire logic        wait_exec_i,
   input  wire logic        stop_exec_i,
   input  wire logic        ref_tick_i,
   input  wire wake_req_s   wake_i,
   input  wire reset_req_s  reset_i,
   output logic             cpu_clk_en_o,
   output logic             bus_clk_en_o,
   output logic             ref_clk_run_o,
   output logic             irq_mask_o,
   output logic             vec_load_o,
   output logic [15:0]      vec_addr_o,
   output logic             sys_reset_o,
   // Peripheral controls
   output logic             spi_run_o,
   output logic             spi_reset_o,
   output logic             timer_run_o,
   output logic             tb_run_o,
   output logic             tb_access_o
);

   localparam int NSRC = $bits(wake_req_s);

   // The recovery counter is 12 bits wide, so 4096 is its ceiling
   if (REC_LONG_CYC < 2 || REC_LONG_CYC > 4096 ||
       REC_SHORT_CYC < 2 || REC_SHORT_CYC > REC_LONG_CYC) begin : g_bad_rec
      $error("recovery counts out of range");
   end

   function automatic logic [15:0] vec_of(input logic [NSRC-1:0] req);
      logic [15:0] v;
      v = `VEC_BASE;
      for (int i = 0; i < NSRC; i++) begin
         if (req[i])
            v = `VEC_BASE + 16'(2 * i);
      end
      return v;
   endfunction : vec_of

   lp_state_e        state_r, state_nxt;
   logic [1:0]       ctrl_r, ctrl_nxt;
   logic [NSRC-1:0]  wen_r, wen_nxt;
   logic [11:0]      cnt_r, cnt_nxt;
   logic             rst_wake_r, rst_wake_nxt;
   logic             irq_prev_r, key_prev_r;
   logic             mask_r, mask_nxt;
   logic             vld_r, vld_nxt;
   logic [15:0]      vec_r, vec_nxt;
   logic             srst_r, srst_nxt;
   logic             spirst_r, spirst_nxt;
   logic             ack_r, ack_nxt;
   logic [31:0]      rdat_r, rdat_nxt;

   logic [NSRC-1:0]  req;
   logic [NSRC-1:0]  wait_wake;
   logic [NSRC-1:0]  stop_wake;
   logic [NSRC-1:0]  stop_mask;
   logic             rst_evt;
   logic [11:0]      term;
   logic             osc_stop;

   assign osc_stop = ctrl_r[`CTRL_OSC_STOP];
   assign rst_evt  = !reset_i.ext_reset_n || reset_i.watchdog ||
                     reset_i.low_voltage;

   // Pins wake on falling edge; other sources are request levels
   always_comb begin
      req         = wake_i;
      req[15]     = irq_prev_r && !wake_i.irq_pin;
      req[2]      = key_prev_r && !wake_i.keypad;
      wait_wake   = req & wen_r;
      stop_mask   = `STOP_WAKE_MASK;
      stop_mask[`TB_BIT] = osc_stop;
      stop_wake   = req & wen_r & stop_mask;
   end

   assign term = ctrl_r[`CTRL_SHORT_REC] ?
                 12'(REC_SHORT_CYC - 1) : 12'(REC_LONG_CYC - 1);

   // Mode sequencing
   always_comb begin
      state_nxt    = state_r;
      cnt_nxt      = cnt_r;
      rst_wake_nxt = rst_wake_r;
      mask_nxt     = mask_r;
      vld_nxt      = 1'b0;
      vec_nxt      = vec_r;
      srst_nxt     = 1'b0;
      spirst_nxt   = 1'b0;
      case (state_r)
         ST_RUN: begin
            if (rst_evt) begin
               srst_nxt = 1'b1;
               mask_nxt = 1'b1;
               vld_nxt  = 1'b1;
               vec_nxt  = `VEC_RESET;
            end else if (stop_exec_i) begin
               state_nxt = ST_STOP;
               mask_nxt  = 1'b0;
            end else if (wait_exec_i) begin
               state_nxt = ST_WAIT;
               mask_nxt  = 1'b0;
            end
         end
         ST_WAIT: begin
            if (rst_evt) begin
               state_nxt = ST_RUN;
               srst_nxt  = 1'b1;
               mask_nxt  = 1'b1;
               vld_nxt   = 1'b1;
               vec_nxt   = `VEC_RESET;
            end else if (|wait_wake) begin
               state_nxt = ST_RUN;
               vld_nxt   = 1'b1;
               vec_nxt   = vec_of(wait_wake);
            end
         end
         ST_STOP: begin
            if (rst_evt) begin
               state_nxt    = ST_REC;
               cnt_nxt      = 12'h000;
               rst_wake_nxt = 1'b1;
               srst_nxt     = 1'b1;
               spirst_nxt   = 1'b1;
               mask_nxt     = 1'b1;
               vec_nxt      = `VEC_RESET;
            end else if (|stop_wake) begin
               state_nxt    = ST_REC;
               cnt_nxt      = 12'h000;
               rst_wake_nxt = 1'b0;
               vec_nxt      = vec_of(stop_wake);
            end
         end
         ST_REC: begin
            if (ref_tick_i) begin
               if (cnt_r == term) begin
                  state_nxt = ST_RUN;
                  vld_nxt   = 1'b1;
               end else begin
                  cnt_nxt = cnt_r + 12'h001;
               end
            end
         end
         default: begin
            state_nxt = ST_RUN;
         end
      endcase
   end

   // Wishbone register access, answered one cycle after the strobe
   always_comb begin
      ctrl_nxt = ctrl_r;
      wen_nxt  = wen_r;
      ack_nxt  = cyc_i && stb_i && !ack_r;
      rdat_nxt = rdat_r;
      if (ack_nxt) begin
         rdat_nxt = 32'h0;
         if (we_i) begin
            if (adr_i == `ADR_CTRL && sel_i[0])
               ctrl_nxt = dat_i[1:0];
            if (adr_i == `ADR_WAKE_EN) begin
               if (sel_i[0])
                  wen_nxt[7:0] = dat_i[7:0];
               if (sel_i[1])
                  wen_nxt[15:8] = dat_i[15:8];
               if (sel_i[2])
                  wen_nxt[16] = dat_i[16];
            end
         end else begin
            case (adr_i)
               `ADR_CTRL:    rdat_nxt = {30'h0, ctrl_r};
               `ADR_WAKE_EN: rdat_nxt = {15'h0, wen_r};
               `ADR_STATUS:  rdat_nxt = {26'h0, rst_wake_r, mask_r,
                                         state_r};
               `ADR_VECTOR:  rdat_nxt = {16'h0, vec_r};
               default:      rdat_nxt = 32'h0;
            endcase
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_r    <= ST_RUN;
         ctrl_r     <= `CTRL_RESET;
         wen_r      <= `WAKE_EN_RESET;
         cnt_r      <= 12'h000;
         rst_wake_r <= 1'b0;
         irq_prev_r <= 1'b1;
         key_prev_r <= 1'b1;
         mask_r     <= 1'b1;
         vld_r      <= 1'b0;
         vec_r      <= `VEC_RESET;
         srst_r     <= 1'b0;
         spirst_r   <= 1'b0;
         ack_r      <= 1'b0;
         rdat_r     <= 32'h0;
      end else begin
         state_r    <= state_nxt;
         ctrl_r     <= ctrl_nxt;
         wen_r      <= wen_nxt;
         cnt_r      <= cnt_nxt;
         rst_wake_r <= rst_wake_nxt;
         irq_prev_r <= wake_i.irq_pin;
         key_prev_r <= wake_i.keypad;
         mask_r     <= mask_nxt;
         vld_r      <= vld_nxt;
         vec_r      <= vec_nxt;
         srst_r     <= srst_nxt;
         spirst_r   <= spirst_nxt;
         ack_r      <= ack_nxt;
         rdat_r     <= rdat_nxt;
      end
   end

   // Enables are registered from the next state, so they move on the
   // same edge as the state; a decoded enable could glitch meanwhile.
   logic             go_run;
   logic             go_awake;
   logic             go_osc_stop;
   logic             go_dark;
   logic             cpu_en_r, cpu_en_nxt;
   logic             bus_en_r, bus_en_nxt;
   logic             ref_run_r, ref_run_nxt;
   logic             spi_run_r, spi_run_nxt;
   logic             tim_run_r, tim_run_nxt;
   logic             tb_run_r, tb_run_nxt;
   logic             tb_acc_r, tb_acc_nxt;

   assign go_run      = (state_nxt == ST_RUN);
   assign go_awake    = go_run || (state_nxt == ST_WAIT);
   assign go_osc_stop = (state_nxt == ST_STOP) && ctrl_nxt[`CTRL_OSC_STOP];
   assign go_dark     = (state_nxt == ST_STOP) && !ctrl_nxt[`CTRL_OSC_STOP];

   always_comb begin
      cpu_en_nxt  = go_run;
      bus_en_nxt  = go_awake || go_osc_stop;
      ref_run_nxt = !go_dark;
      spi_run_nxt = go_awake;
      tim_run_nxt = go_awake;
      tb_run_nxt  = go_awake || go_osc_stop;
      tb_acc_nxt  = go_run;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cpu_en_r  <= 1'b1;
         bus_en_r  <= 1'b1;
         ref_run_r <= 1'b1;
         spi_run_r <= 1'b1;
         tim_run_r <= 1'b1;
         tb_run_r  <= 1'b1;
         tb_acc_r  <= 1'b1;
      end else begin
         cpu_en_r  <= cpu_en_nxt;
         bus_en_r  <= bus_en_nxt;
         ref_run_r <= ref_run_nxt;
         spi_run_r <= spi_run_nxt;
         tim_run_r <= tim_run_nxt;
         tb_run_r  <= tb_run_nxt;
         tb_acc_r  <= tb_acc_nxt;
      end
   end

   assign cpu_clk_en_o  = cpu_en_r;
   assign bus_clk_en_o  = bus_en_r;
   assign ref_clk_run_o = ref_run_r;
   assign spi_run_o     = spi_run_r;
   assign timer_run_o   = tim_run_r;
   assign tb_run_o      = tb_run_r;
   assign tb_access_o   = tb_acc_r;
   assign irq_mask_o    = mask_r;
   assign vec_load_o    = vld_r;
   assign vec_addr_o    = vec_r;
   assign sys_reset_o   = srst_r;
   assign spi_reset_o   = spirst_r;
   assign ack_o         = ack_r;
   assign dat_o         = rdat_r;

   // Checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_wait_cpu_off: assert property (
      state_r == ST_WAIT |-> !cpu_clk_en_o && bus_clk_en_o)
      else $error("wait clock gating wrong");
   a_stop_bus_gate: assert property (
      state_r == ST_STOP |-> !cpu_clk_en_o && bus_clk_en_o == osc_stop)
      else $error("stop clock gating wrong");
   a_tb_locked: assert property (
      state_r inside {ST_WAIT, ST_STOP} |-> !tb_access_o)
      else $error("timebase reachable in low power");
   a_periph_frozen: assert property (
      state_r == ST_STOP |-> !timer_run_o && !spi_run_o)
      else $error("peripherals run in stop");
   a_reset_vector: assert property (
      state_r == ST_WAIT && rst_evt |=> vld_r && vec_r == `VEC_RESET
      && mask_r)
      else $error("reset did not win");
   a_wait_mask: assert property (
      state_r == ST_RUN && !rst_evt && (wait_exec_i || stop_exec_i)
      |=> !mask_r)
      else $error("mask not cleared on entry");
   a_irq_vector: assert property (
      state_r == ST_WAIT && !rst_evt && req[15] && wen_r[15] &&
      !(req[16] && wen_r[16]) |=> vec_r == 16'hfffa)
      else $error("interrupt pin vector wrong");
   a_stop_spi_rst: assert property (
      state_r == ST_STOP && rst_evt |=> spi_reset_o && state_r == ST_REC)
      else $error("serial port not reset");
   a_rec_release: assert property (
      state_r == ST_REC && ref_tick_i && cnt_r == term
      |=> state_r == ST_RUN ##1 cpu_clk_en_o)
      else $error("recovery release wrong");
   a_rec_count: assert property (
      state_r == ST_STOP && $past(state_r) == ST_STOP ##1
      state_r == ST_REC |-> cnt_r == 12'h000)
      else $error("recovery counter not cleared");
   a_rec_gated: assert property (
      state_r == ST_REC |-> !cpu_clk_en_o && !bus_clk_en_o)
      else $error("clocks run during recovery");
   a_dark_stop: assert property (
      state_r == ST_STOP && !osc_stop |-> !ref_clk_run_o && !tb_run_o)
      else $error("clocks run in dark stop");

endmodule : low_power_wake_and_vector_control

//--- lp_params.svh
// Summary of operation
// - Serial port runs in wait, can wake
// - Serial port frozen in stop, resumes after interrupt
// - Reset ending stop resets serial port
// - Both timers run in wait, can wake
// - Timers frozen in stop, resume after interrupt
// - Timebase runs in wait, register access blocked
// - Timebase runs in stop only with oscillator
// - Timebase register blocked throughout stop
// - Timebase rollover in stop wakes via FFDC
// - Pin, watchdog, low supply reset via FFFE
// - Interrupt pin falling edge wakes via FFFA
// - Break interrupt wakes via FFFC
// - Clock generator FFF8, keypad FFE0 on wait exit
// - Timer one: FFF2, FFF4, FFF6
// - Timer two: FFEC, FFEE, FFF0
// - Serial port: transmit FFE8, receive FFEA
// - Async serial: FFE2, FFE4, FFE6
// - Converter FFDE, timebase FFDC on wait exit
// - Only listed events end stop, restart clocks
// - Recovery holds clocks 4096 reference cycles
// - Short recovery select gives 32 cycles
// - Stop halts CPU, bus clock unless oscillator
// - Wait/stop clear mask; reset wake sets it
// - Stop without oscillator holds clocks low
`ifndef LP_PARAMS_SVH
`define LP_PARAMS_SVH

`define ADR_CTRL        4'h0
`define ADR_WAKE_EN     4'h4
`define ADR_STATUS      4'h8
`define ADR_VECTOR      4'hc

`define CTRL_SHORT_REC  0
`define CTRL_OSC_STOP   1
`define CTRL_RESET      2'h0
`define WAKE_EN_RESET   17'h1ffff

`define VEC_BASE        16'hffdc
`define VEC_RESET       16'hfffe
`define STOP_WAKE_MASK  17'h18005
`define TB_BIT          0

`define REC_LONG        4096
`define REC_SHORT       32

`endif

//--- lp_pkg.sv
package lp_pkg;

   typedef enum logic [3:0] {
      ST_RUN  = 4'b0001,
      ST_WAIT = 4'b0010,
      ST_STOP = 4'b0100,
      ST_REC  = 4'b1000
   } lp_state_e;

   // Field order puts the highest-priority source at the top bit;
   // vector address is base plus twice the bit index.
   typedef struct packed {
      logic brk;
      logic irq_pin;
      logic clkgen;
      logic timer_unit_one_ch0;
      logic timer_unit_one_ch1;
      logic timer_unit_one_ovf;
      logic timer_unit_two_ch0;
      logic timer_unit_two_ch1;
      logic timer_unit_two_ovf;
      logic spi_rx;
      logic spi_tx;
      logic sci_err;
      logic sci_rx;
      logic sci_tx;
      logic keypad;
      logic adc;
      logic timebase;
   } wake_req_s;

   typedef struct packed {
      logic ext_reset_n;
      logic watchdog;
      logic low_voltage;
   } reset_req_s;

endpackage : lp_pkg

//--- cpu_model.sv
`timescale 1ns/1ps
// CPU core and wake pins: the core issues wait or stop only while its
// clock runs; the reference oscillator ticks only while it is let run.
module cpu_model (
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   // From the block
   input  wire logic       cpu_clk_en_i,
   input  wire logic       ref_run_i,
   // From the bench
   input  wire logic [1:0] go_i,
   input  wire logic [1:0] pin_low_i,
   // To the block
   output logic            wait_exec_o,
   output logic            stop_exec_o,
   output logic            ref_tick_o,
   output logic [1:0]      pins_o
);
   logic ph_r;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ph_r        <= 1'b0;
         ref_tick_o  <= 1'b0;
         wait_exec_o <= 1'b0;
         stop_exec_o <= 1'b0;
         pins_o      <= 2'b11;
      end else begin
         ph_r        <= ~ph_r;
         // A held-low reference clock gives no ticks at all
         ref_tick_o  <= ref_run_i & ph_r;
         wait_exec_o <= go_i[0] & cpu_clk_en_i;
         stop_exec_o <= go_i[1] & cpu_clk_en_i;
         // Pins idle high; a wake is the fall to low
         pins_o      <= ~pin_low_i;
      end
   end
endmodule : cpu_model

//--- testbench.sv
`timescale 1ns/1ps
module testbench;
   import lp_pkg::*;
   localparam int NL = 8;
   localparam int NS = 4;
   logic        clk_i = 1'b0, rst_i = 1'b1;
   logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [3:0]  adr = 4'h0, sel = 4'h0;
   logic [31:0] dat = 32'h0, dat_o, rd;
   logic        ack_o, wx, sx, tick, cpu_en, bus_en, ref_run, mask;
   logic        vld, sreset, spi_rst, spi_run, tim_run, tb_run, tb_acc;
   logic [15:0] vec;
   logic [7:0]  gates;
   logic [1:0]  go = 2'b00, plow = 2'b00, pins;
   logic [16:0] req = 17'h0, en, rr;
   reset_req_s  rq = 3'b100;
   wake_req_s   wk;
   logic        seen_sr = 1'b0, seen_spi = 1'b0;
   logic [31:0] seed = 32'd41573;
   int          fail_count = 0, n_tests = 0, cyc_n = 0, t;
   logic [3:0]  ra[5] = '{4'h0, 4'h4, 4'h8, 4'hc, 4'h2};
   logic [31:0] rv[5] = '{32'h0, 32'h1ffff, 32'h11, 32'hfffe, 32'h0};
   int          src[4] = '{15, 2, 0, 16};

   always #12.5 clk_i = ~clk_i;
   assign gates = {cpu_en, bus_en, ref_run, spi_run, tim_run, tb_run,
                   tb_acc, mask};
   always_comb begin
      wk = req;
      wk.irq_pin = pins[1];
      wk.keypad = pins[0];
   end

   low_power_wake_and_vector_control #(.REC_LONG_CYC(NL),
      .REC_SHORT_CYC(NS)) dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
      .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat),
      .dat_o(dat_o), .ack_o(ack_o), .wait_exec_i(wx), .stop_exec_i(sx),
      .ref_tick_i(tick), .wake_i(wk), .reset_i(rq), .cpu_clk_en_o(cpu_en),
      .bus_clk_en_o(bus_en), .ref_clk_run_o(ref_run), .irq_mask_o(mask),
      .vec_load_o(vld), .vec_addr_o(vec), .sys_reset_o(sreset),
      .spi_reset_o(spi_rst), .spi_run_o(spi_run), .timer_run_o(tim_run),
      .tb_run_o(tb_run), .tb_access_o(tb_acc));
   cpu_model cpu (.clk_i(clk_i), .rst_i(rst_i), .cpu_clk_en_i(cpu_en),
      .ref_run_i(ref_run), .go_i(go), .pin_low_i(plow), .wait_exec_o(wx),
      .stop_exec_o(sx), .ref_tick_o(tick), .pins_o(pins));

   // Timeout sized well above the few hundred cycles the tests need
   always @(posedge clk_i) begin
      cyc_n++;
      if (sreset === 1'b1) seen_sr = 1'b1;
      if (spi_rst === 1'b1) seen_spi = 1'b1;
      if (cyc_n > 6000) begin
         fail_count++;
         final_report();
      end
   end

   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xs

   // Highest pending source wins; vector is base plus twice its index
   function automatic logic [15:0] vexp(input logic [16:0] m);
      for (int i = 16; i >= 0; i--)
         if (m[i]) return 16'(32'hffdc + 2 * i);
      return 16'hfffe;
   endfunction : vexp

   task automatic chk(input logic [31:0] g, e, input string m);
      n_tests++;
      if (g !== e) begin
         fail_count++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, m, g, e);
      end
   endtask : chk

   task automatic wb(input logic w, input logic [3:0] a,
                     input logic [31:0] d);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we  <= w;
      adr <= a;
      dat <= d;
      sel <= 4'hf;
      // Only the bench timeout ends a wait for the answer
      do begin
         @(posedge clk_i);
      end while (ack_o !== 1'b1);
      rd = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk_i);
   endtask : wb

   task automatic enter(input int s);
      @(posedge clk_i);
      go <= 2'b01 << s;
      @(posedge clk_i);
      go <= 2'b00;
      repeat (2) @(posedge clk_i);
   endtask : enter

   // Called on the edge that drives the waking request; counts reference ticks
   // up to the vector load. A negative tick figure skips that check.
   task automatic wake(input logic [15:0] ev, input int et);
      t = 0;
      @(posedge clk_i);
      rq <= 3'b100;
      do begin
         @(posedge clk_i);
         if (vld !== 1'b1 && tick === 1'b1) t++;
      end while (vld !== 1'b1);
      chk(vec, ev, "vector");
      if (et >= 0) chk(t, et, "recovery ticks");
      req  <= 17'h0;
      plow <= 2'b00;
   endtask : wake

   task automatic final_report();
      $display("comparisons %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : final_report

   initial begin
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      for (int i = 0; i < 5; i++) begin
         wb(1'b0, ra[i], 32'h0);
         chk(rd, rv[i], "reset value");
      end
      $display("reset values done");
      for (int i = 0; i < 17; i++) begin
         enter(0);
         chk(gates, 8'h7c, "wait gating");
         @(posedge clk_i);
         if (i == 15) plow <= 2'b10;
         else if (i == 2) plow <= 2'b01;
         else req <= 17'h1 << i;
         wake(vexp(17'h1 << i), -1);
         chk(mask, 1'b0, "mask after wake");
      end
      $display("wait sources done");
      for (int n = 0; n < 6; n++) begin
         en = 17'(xs()) | 17'h1;
         rr = (17'(xs()) & 17'h17ffb) | 17'h1;
         wb(1'b1, 4'h4, 32'(en));
         enter(0);
         @(posedge clk_i);
         req <= rr;
         wake(vexp(en & rr), -1);
      end
      wb(1'b1, 4'h4, 32'h1ffff);
      $display("random wait wakes done");
      for (int k = 0; k < 4; k++) begin
         wb(1'b1, 4'h0, 32'(k));
         enter(1);
         chk(gates, {1'b0, k[1], k[1], 2'b00, k[1], 2'b00},
             "stop gating");
         @(posedge clk_i);
         req <= 17'h04880 | (k[1] ? 17'h0 : 17'h1);
         repeat (12) @(posedge clk_i);
         wb(1'b0, 4'h8, 32'h0);
         chk(rd, 32'h4, "refused wake in stop");
         @(posedge clk_i);
         if (src[k] == 15) plow <= 2'b10;
         else if (src[k] == 2) plow <= 2'b01;
         else req <= 17'h04880 | (17'h1 << src[k]);
         wake(vexp(17'h1 << src[k]),
              k[0] ? NS : NL);
         chk(gates, 8'hfe, "run gating");
      end
      wb(1'b1, 4'h0, 32'h0);
      $display("stop exits done");
      for (int r = 0; r < 3; r++) begin
         enter(r == 0);
         seen_sr = 1'b0;
         seen_spi = 1'b0;
         @(posedge clk_i);
         rq <= (r == 0) ? 3'b000 : (r == 1) ? 3'b110 : 3'b101;
         if (r == 1) req <= 17'h10000;
         wake(16'hfffe, (r == 0) ? NL : -1);
         // Let the pulse watcher sample the reset pulses first
         @(posedge clk_i);
         chk({seen_sr, seen_spi, mask}, {1'b1, r == 0, 1'b1},
             "reset wake");
      end
      wb(1'b0, 4'h8, 32'h0);
      chk(rd, 32'h31, "status after reset");
      $display("reset wakes done");
      final_report();
   end
endmodule : testbench
